/* design/gd_pkg.sv */
// shared constants and types for the graphics operation dispatcher
// ====================
package gd_pkg;
  // ====================
  // address map
  localparam int ADDR_W = 16;
  localparam int FB_BIT = 15;
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_SLOPE = 8'h20;
  localparam logic [7:0] OFS_SPAN = 8'h40;
  localparam logic [7:0] OFS_SETUP = 8'h60;
  localparam logic [7:0] OFS_CONT = 8'h80;
  localparam logic [7:0] OFS_OPADDR = 8'h84;
  localparam logic [7:0] OFS_CSRC = 8'h88;
  localparam logic [7:0] OFS_CDST = 8'h8C;
  localparam logic [7:0] OFS_STAT = 8'h90;
  localparam logic [7:0] OFS_COUNT = 8'h94;
  // ====================
  // fields and reset values
  localparam int DEEP_BIT = 8;
  localparam int CONT_ADDR_BIT = 31;
  localparam logic [31:0] SLOPE_MASK = 32'h0000FFFF;
  localparam logic [8:0] MODE_RST = 9'h000;
  localparam logic [23:0] OPADDR_RST = 24'h000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  // ====================
  // lengths: pixels for drawing, bytes for copy and dma
  localparam logic [15:0] LEN_WORD = 16'h0001;
  localparam logic [15:0] LEN_STIP = 16'h0020;
  localparam logic [15:0] LEN_FILL = 16'h0800;
  localparam logic [15:0] LEN_LINE = 16'h0010;
  localparam logic [15:0] LEN_COPY_HALF = 16'h0020;
  localparam logic [15:0] LEN_COPY_FULL = 16'h0040;
  localparam logic [15:0] LEN_DMA_WR = 16'h4000;
  localparam logic [15:0] LEN_DMA_RD = 16'h2000;
  // ====================
  // command queue
  localparam int QDEPTH = 16;
  localparam int QAW = 4;
  localparam int QW = 48;
  // ====================
  // modes and operation kinds
  typedef enum logic [4:0] {
    M_SIMPLE = 5'h00, M_SIMPLE_Z = 5'h01, M_STIP_TR = 5'h02, M_STIP_OP = 5'h03,
    M_STIP_BLK = 5'h04, M_FILL_BLK = 5'h05, M_FILL_OP = 5'h06, M_FILL_TR = 5'h07,
    M_LINE_TR = 5'h08, M_LINE_OP = 5'h09, M_COPY = 5'h0A, M_DMA_WR = 5'h0B,
    M_DMA_RD = 5'h0C, M_L3_CI = 5'h0D, M_L3_CID = 5'h0E, M_L3_SEQ = 5'h0F,
    M_L3_Z = 5'h10, M_L3_ZCI = 5'h11, M_L3_ZCID = 5'h12, M_L3_ZSEQ = 5'h13
  } gd_mode_t;
  typedef enum logic [4:0] {
    OP_NONE = 5'h00, OP_PIX = 5'h01, OP_PIX_Z = 5'h02, OP_STIP_1C = 5'h03,
    OP_STIP_2C = 5'h04, OP_STIP_PAT = 5'h05, OP_FILL_BLK = 5'h06, OP_FILL_2C = 5'h07,
    OP_FILL_1C = 5'h08, OP_LINE_1C = 5'h09, OP_LINE_2C = 5'h0A, OP_COPY_LOAD = 5'h0B,
    OP_COPY_UNLOAD = 5'h0C, OP_DMA_WR = 5'h0D, OP_DMA_RD = 5'h0E, OP_L3_CI = 5'h0F,
    OP_L3_CID = 5'h10, OP_L3_SEQ = 5'h11, OP_L3_Z = 5'h12, OP_L3_ZCI = 5'h13,
    OP_L3_ZCID = 5'h14, OP_L3_ZSEQ = 5'h15, OP_LINE_SETUP = 5'h16, OP_LINE_CONT = 5'h17
  } gd_op_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1, ST_RUN = 3'h2, ST_SYNC = 3'h4
  } gd_state_t;
endpackage

/* design/gd_cmd_queue.sv */
// sixteen-entry command queue between bus writes and the dispatcher
`timescale 1ns/10ps
module gd_cmd_queue (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic push,
  input wire logic [gd_pkg::QW-1:0] din,
  output logic full,
  input wire logic pop,
  output logic [gd_pkg::QW-1:0] dout,
  output logic empty,
  output logic [gd_pkg::QAW:0] level
);
  logic [gd_pkg::QW-1:0] mem_q [gd_pkg::QDEPTH];
  logic [gd_pkg::QAW:0] wp_q;
  logic [gd_pkg::QAW:0] rp_q;

  // extra pointer bit tells full from empty
  assign level = wp_q - rp_q;
  assign full = level[gd_pkg::QAW];
  assign empty = (wp_q == rp_q);
  assign dout = mem_q[rp_q[gd_pkg::QAW-1:0]];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_q <= '0;
    end else if (push && !full) begin
      wp_q <= wp_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rp_q <= '0;
    end else if (pop && !empty) begin
      rp_q <= rp_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (push && !full) begin
      mem_q[wp_q[gd_pkg::QAW-1:0]] <= din;
    end
  end
endmodule // gd_cmd_queue

/* design/gd_dispatch.sv */
// graphics operation dispatcher with axi4-lite slave and command queue
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
module gd_dispatch (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic eng_done,
  input wire logic eng_idle,
  output logic op_start,
  output logic [4:0] op_kind,
  output logic [23:0] op_addr,
  output logic [31:0] op_data,
  output logic [15:0] op_len,
  output logic [2:0] op_slope,
  output logic op_deep
);
  // ====================
  // state
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [14:0] aw_off_q;
  logic aw_fb_q;
  logic [31:0] w_data_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [8:0] mode_q;
  logic [23:0] opaddr_q;
  logic copy_full_q;
  logic [15:0] count_q;
  gd_pkg::gd_state_t st_q;
  logic start_q;
  gd_pkg::gd_op_t kind_q;
  logic [23:0] addr_q;
  logic [31:0] data_q;
  logic [15:0] len_q;
  logic [2:0] slope_q;
  logic deep_q;
  // ====================
  // queue
  logic q_push;
  logic q_full;
  logic q_pop;
  logic q_empty;
  logic [gd_pkg::QW-1:0] q_dout;
  logic [gd_pkg::QAW:0] q_level;
  logic e_fb;
  logic [14:0] e_off;
  logic [31:0] e_data;
  logic e_reg;
  logic [7:0] roff;

  // both halves held and no answer pending: store the write
  assign q_push = !awready_q && !wready_q && !bvalid_q;
  assign q_pop = (st_q == gd_pkg::ST_IDLE) && !q_empty;
  assign e_fb = q_dout[47];
  assign e_off = q_dout[46:32];
  assign e_data = q_dout[31:0];
  assign e_reg = !e_fb && (e_off[14:8] == 7'h00);
  assign roff = e_off[7:0];

  gd_cmd_queue u_queue (
    .aclk(aclk),
    .aresetn(aresetn),
    .push(q_push),
    .din({aw_fb_q, aw_off_q, w_data_q}),
    .full(q_full),
    .pop(q_pop),
    .dout(q_dout),
    .empty(q_empty),
    .level(q_level)
  );

  // ====================
  // axi write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      aw_off_q <= '0;
      aw_fb_q <= 1'b0;
    end else if (s_axi_awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_off_q <= s_axi_awaddr[14:0];
      aw_fb_q <= s_axi_awaddr[gd_pkg::FB_BIT];
    end else if (bvalid_q && s_axi_bready) begin
      awready_q <= 1'b1;
    end
  end

  // byte strobes ignored: registers take whole words only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b1;
      w_data_q <= '0;
    end else if (s_axi_wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_data_q <= s_axi_wdata;
    end else if (bvalid_q && s_axi_bready) begin
      wready_q <= 1'b1;
    end
  end

  // full queue stalls the response, which is the back-pressure
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
    end else if (q_push && !q_full) begin
      bvalid_q <= 1'b1;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ====================
  // axi read channel
  logic busy;
  assign busy = (st_q != gd_pkg::ST_IDLE) || !q_empty || !eng_idle;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      // frame-buffer and unmapped reads answer zero
      if (s_axi_araddr[gd_pkg::FB_BIT] || s_axi_araddr[14:8] != 7'h00) begin
        rdata_q <= '0;
      end else begin
        case (s_axi_araddr[7:0])
          gd_pkg::OFS_MODE: rdata_q <= {23'h000000, mode_q};
          gd_pkg::OFS_OPADDR: rdata_q <= {8'h00, opaddr_q};
          gd_pkg::OFS_STAT: rdata_q <= {24'h000000, q_level, 1'b0, copy_full_q, busy};
          gd_pkg::OFS_COUNT: rdata_q <= {16'h0000, count_q};
          default: rdata_q <= '0;
        endcase
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ====================
  // mode decode
  gd_pkg::gd_mode_t mode;
  logic deep;
  logic is3d;
  logic is_line;
  gd_pkg::gd_op_t mk;
  gd_pkg::gd_op_t lk;
  assign mode = gd_pkg::gd_mode_t'(mode_q[4:0]);
  assign deep = mode_q[gd_pkg::DEEP_BIT];
  assign is3d = (mode >= gd_pkg::M_L3_CI) && (mode <= gd_pkg::M_L3_ZSEQ);
  assign is_line = is3d || mode == gd_pkg::M_LINE_TR || mode == gd_pkg::M_LINE_OP;

  // operation of a frame-buffer write; 3d modes have none
  always_comb begin
    mk = gd_pkg::OP_NONE;
    case (mode)
      gd_pkg::M_SIMPLE: mk = gd_pkg::OP_PIX;
      gd_pkg::M_SIMPLE_Z: mk = gd_pkg::OP_PIX_Z;
      gd_pkg::M_STIP_TR: mk = gd_pkg::OP_STIP_1C;
      gd_pkg::M_STIP_OP: mk = gd_pkg::OP_STIP_2C;
      gd_pkg::M_STIP_BLK: mk = gd_pkg::OP_STIP_PAT;
      gd_pkg::M_FILL_BLK: mk = gd_pkg::OP_FILL_BLK;
      gd_pkg::M_FILL_OP: mk = gd_pkg::OP_FILL_2C;
      gd_pkg::M_FILL_TR: mk = gd_pkg::OP_FILL_1C;
      gd_pkg::M_LINE_TR: mk = gd_pkg::OP_LINE_1C;
      gd_pkg::M_LINE_OP: mk = gd_pkg::OP_LINE_2C;
      gd_pkg::M_COPY: begin
        mk = copy_full_q ? gd_pkg::OP_COPY_UNLOAD : gd_pkg::OP_COPY_LOAD;
      end
      gd_pkg::M_DMA_WR: mk = gd_pkg::OP_DMA_WR;
      gd_pkg::M_DMA_RD: mk = gd_pkg::OP_DMA_RD;
      default: mk = gd_pkg::OP_NONE;
    endcase
  end

  // drawing kind of a slope or span write in line modes
  always_comb begin
    lk = gd_pkg::OP_NONE;
    case (mode)
      gd_pkg::M_LINE_TR: lk = gd_pkg::OP_LINE_1C;
      gd_pkg::M_LINE_OP: lk = gd_pkg::OP_LINE_2C;
      gd_pkg::M_L3_CI: lk = gd_pkg::OP_L3_CI;
      gd_pkg::M_L3_CID: lk = gd_pkg::OP_L3_CID;
      gd_pkg::M_L3_Z: lk = gd_pkg::OP_L3_Z;
      gd_pkg::M_L3_ZCI: lk = gd_pkg::OP_L3_ZCI;
      gd_pkg::M_L3_ZCID: lk = gd_pkg::OP_L3_ZCID;
      // grey shading only on 8 bpp buffers
      gd_pkg::M_L3_SEQ: lk = deep ? gd_pkg::OP_NONE : gd_pkg::OP_L3_SEQ;
      gd_pkg::M_L3_ZSEQ: lk = deep ? gd_pkg::OP_NONE : gd_pkg::OP_L3_ZSEQ;
      default: lk = gd_pkg::OP_NONE;
    endcase
  end

  // ====================
  // entry decode
  gd_pkg::gd_op_t dk;
  logic [23:0] daddr;
  logic [31:0] ddata;
  logic [2:0] dslope;
  logic dcmd;
  logic [15:0] dlen;
  logic wr_mode;
  logic wr_opaddr;
  logic wr_sync;

  always_comb begin
    dk = gd_pkg::OP_NONE;
    daddr = opaddr_q;
    ddata = e_data;
    dslope = 3'h0;
    dcmd = 1'b0;
    wr_mode = 1'b0;
    wr_opaddr = 1'b0;
    wr_sync = 1'b0;
    if (e_fb) begin
      dk = mk;
      daddr = {9'h000, e_off};
    end else if (e_reg) begin
      if (roff[7:5] == gd_pkg::OFS_SLOPE[7:5]) begin
        dk = lk;
        dslope = roff[4:2];
      end else if (roff[7:5] == gd_pkg::OFS_SETUP[7:5]) begin
        dk = is_line ? gd_pkg::OP_LINE_SETUP : gd_pkg::OP_NONE;
        dslope = roff[4:2];
      end else if (roff == gd_pkg::OFS_SPAN) begin
        dk = lk;
        ddata = e_data & gd_pkg::SLOPE_MASK;
      end else if (roff == gd_pkg::OFS_CONT) begin
        if (is_line) begin
          dk = gd_pkg::OP_LINE_CONT;
        end else begin
          dk = mk;
          if (!e_data[gd_pkg::CONT_ADDR_BIT]) begin
            daddr = e_data[23:0];
          end
        end
      end else if (roff == gd_pkg::OFS_CSRC) begin
        dk = (mode == gd_pkg::M_COPY) ? gd_pkg::OP_COPY_LOAD : gd_pkg::OP_NONE;
        dcmd = 1'b1;
      end else if (roff == gd_pkg::OFS_CDST) begin
        dk = (mode == gd_pkg::M_COPY) ? gd_pkg::OP_COPY_UNLOAD : gd_pkg::OP_NONE;
        dcmd = 1'b1;
      end else if (roff == gd_pkg::OFS_MODE) begin
        wr_mode = 1'b1;
      end else if (roff == gd_pkg::OFS_OPADDR) begin
        wr_opaddr = 1'b1;
      end else if (roff == gd_pkg::OFS_STAT) begin
        wr_sync = 1'b1;
      end
    end
  end

  // frame-buffer copy at 8 bpp fills half the buffer
  always_comb begin
    dlen = gd_pkg::LEN_LINE;
    case (dk)
      gd_pkg::OP_PIX, gd_pkg::OP_PIX_Z: dlen = gd_pkg::LEN_WORD;
      gd_pkg::OP_STIP_1C, gd_pkg::OP_STIP_2C, gd_pkg::OP_STIP_PAT: dlen = gd_pkg::LEN_STIP;
      gd_pkg::OP_FILL_BLK, gd_pkg::OP_FILL_2C, gd_pkg::OP_FILL_1C: dlen = gd_pkg::LEN_FILL;
      gd_pkg::OP_COPY_LOAD, gd_pkg::OP_COPY_UNLOAD: begin
        dlen = (deep || dcmd) ? gd_pkg::LEN_COPY_FULL : gd_pkg::LEN_COPY_HALF;
      end
      gd_pkg::OP_DMA_WR: dlen = gd_pkg::LEN_DMA_WR;
      gd_pkg::OP_DMA_RD: dlen = gd_pkg::LEN_DMA_RD;
      default: dlen = gd_pkg::LEN_LINE;
    endcase
  end

  // ====================
  // control registers, applied in queue order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= gd_pkg::MODE_RST;
      opaddr_q <= gd_pkg::OPADDR_RST;
    end else if (q_pop) begin
      if (wr_mode) begin
        mode_q <= e_data[8:0];
      end
      if (wr_opaddr) begin
        opaddr_q <= e_data[23:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      copy_full_q <= 1'b0;
    end else if (q_pop && dk == gd_pkg::OP_COPY_LOAD) begin
      copy_full_q <= 1'b1;
    end else if (q_pop && dk == gd_pkg::OP_COPY_UNLOAD) begin
      copy_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= '0;
    end else if (q_pop && dk != gd_pkg::OP_NONE) begin
      count_q <= count_q + 1'b1;
    end
  end

  // ====================
  // dispatch sequencer: one operation in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= gd_pkg::ST_IDLE;
    end else begin
      case (st_q)
        gd_pkg::ST_IDLE: begin
          if (q_pop && dk != gd_pkg::OP_NONE) begin
            st_q <= gd_pkg::ST_RUN;
          end else if (q_pop && wr_sync) begin
            st_q <= gd_pkg::ST_SYNC;
          end
        end
        gd_pkg::ST_RUN: begin
          if (eng_done) begin
            st_q <= gd_pkg::ST_IDLE;
          end
        end
        gd_pkg::ST_SYNC: begin
          if (eng_idle) begin
            st_q <= gd_pkg::ST_IDLE;
          end
        end
        default: st_q <= gd_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_q <= 1'b0;
      kind_q <= gd_pkg::OP_NONE;
      addr_q <= '0;
      data_q <= '0;
      len_q <= '0;
      slope_q <= '0;
      deep_q <= 1'b0;
    end else if (q_pop && dk != gd_pkg::OP_NONE) begin
      start_q <= 1'b1;
      kind_q <= dk;
      addr_q <= daddr;
      data_q <= ddata;
      len_q <= dlen;
      slope_q <= dslope;
      deep_q <= deep;
    end else begin
      start_q <= 1'b0;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bresp = gd_pkg::RESP_OKAY;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = gd_pkg::RESP_OKAY;
  assign s_axi_rvalid = rvalid_q;
  assign op_start = start_q;
  assign op_kind = kind_q;
  assign op_addr = addr_q;
  assign op_data = data_q;
  assign op_len = len_q;
  assign op_slope = slope_q;
  assign op_deep = deep_q;

  // ====================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  one_in_flight_a: assert property (st_q == gd_pkg::ST_RUN |-> !q_pop)
    else $error("queue popped while an operation runs");
  start_pulse_a: assert property (op_start |=>
    !op_start && (st_q == gd_pkg::ST_RUN || st_q == gd_pkg::ST_IDLE))
    else $error("start not a single pulse");
  fb_no_3d_a: assert property (q_pop && e_fb && is3d |=> !op_start)
    else $error("frame-buffer write started a 3d operation");
  span_zero_a: assert property (q_pop && e_reg && roff == gd_pkg::OFS_SPAN &&
    is_line && lk != gd_pkg::OP_NONE |=>
    op_start && op_slope == 3'h0 && op_data[31:16] == 16'h0000)
    else $error("span write kept a slope");
  setup_only_a: assert property (q_pop && e_reg && roff[7:5] == 3'h3 &&
    is_line |=> op_kind == gd_pkg::OP_LINE_SETUP)
    else $error("setup write started drawing");
  stip_len_a: assert property (op_start && (op_kind == gd_pkg::OP_STIP_1C ||
    op_kind == gd_pkg::OP_STIP_2C || op_kind == gd_pkg::OP_STIP_PAT) |-> op_len == 16'h0020)
    else $error("stipple span not 32 pixels");
  dma_len_a: assert property (op_start && op_kind == gd_pkg::OP_DMA_WR |->
    op_len == 16'h4000)
    else $error("dma-write length wrong");
  sync_wait_a: assert property (st_q == gd_pkg::ST_SYNC && !eng_idle |=>
    !op_start && st_q == gd_pkg::ST_SYNC)
    else $error("barrier released before engine idle");
  copy_flip_a: assert property (q_pop && e_fb && mode == gd_pkg::M_COPY |=>
    copy_full_q != $past(copy_full_q))
    else $error("copy state did not alternate");
endmodule // gd_dispatch

/* testbench/gd_engine_model.sv */
// drawing engine model answering each launch after a short or long delay
`timescale 1ns/10ps
module gd_engine_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic op_start,
  input wire logic slow,
  output logic eng_done,
  output logic eng_idle
);
  // ====================
  // busy countdown
  logic [4:0] cnt_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_q <= 5'h00;
    else if (op_start) cnt_q <= slow ? 5'h14 : 5'h04;
    else if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
  end
  // done three cycles ahead of idle, so a barrier really has to wait
  assign eng_done = (cnt_q == 5'h03);
  // idle only once nothing is running
  assign eng_idle = (cnt_q == 5'h00) && !op_start;
endmodule // gd_engine_model

/* testbench/gd_dispatch_test.sv */
// self-checking bench for the graphics operation dispatcher
`timescale 1ns/10ps
module gd_dispatch_test;
  // ====================
  // signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic slow = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic awready, wready, bvalid, arready, rvalid, op_start, op_deep, eng_done, eng_idle;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, op_data, rd, d;
  logic [4:0] op_kind;
  logic [23:0] op_addr, opa;
  logic [15:0] op_len;
  logic [2:0] op_slope;
  logic [14:0] ofs;
  typedef struct {logic [4:0] k; logic [23:0] a; logic [15:0] l; logic [31:0] d;
    logic [1:0] c; logic [3:0] p;} gd_note_t;
  gd_note_t exp_q[$];
  gd_note_t e;
  int num_errors = 0, checks_done = 0, cycles = 0, starts = 0;
  logic [15:0] fb_len [13] = '{gd_pkg::LEN_WORD, gd_pkg::LEN_WORD, gd_pkg::LEN_STIP,
    gd_pkg::LEN_STIP, gd_pkg::LEN_STIP, gd_pkg::LEN_FILL, gd_pkg::LEN_FILL, gd_pkg::LEN_FILL,
    gd_pkg::LEN_LINE, gd_pkg::LEN_LINE, gd_pkg::LEN_COPY_HALF, gd_pkg::LEN_DMA_WR,
    gd_pkg::LEN_DMA_RD};
  always #10 aclk = ~aclk;
  gd_dispatch dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .eng_done(eng_done), .eng_idle(eng_idle),
    .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr), .op_data(op_data),
    .op_len(op_len), .op_slope(op_slope), .op_deep(op_deep));
  gd_engine_model eng (.aclk(aclk), .aresetn(aresetn), .op_start(op_start), .slow(slow),
    .eng_done(eng_done), .eng_idle(eng_idle));
  // ====================
  // tasks
  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] x, input logic [31:0] s);
    checks_done++;
    if (s !== x) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, x, s);
    end
  endtask
  task automatic note(input gd_pkg::gd_op_t k, input logic [23:0] a, input logic [15:0] l,
    input logic [31:0] dd, input logic [1:0] c, input logic [3:0] p = 4'h0);
    exp_q.push_back('{k, a, l, dd, c, p});
    starts++;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] dd);
    logic b_ok;
    b_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dd;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        bready <= 1'b0;
        b_ok = 1'b1;
        check("bresp", 32'(gd_pkg::RESP_OKAY), 32'(bresp));
      end
    end
  endtask
  task automatic rd_reg(input logic [15:0] a, output logic [31:0] dd);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    dd = rdata;
    check("rresp", 32'(gd_pkg::RESP_OKAY), 32'(rresp));
    rready <= 1'b0;
  endtask
  task automatic mode(input logic [4:0] m, input logic deep);
    wr({8'h00, gd_pkg::OFS_MODE}, {23'h000000, deep, 3'h0, m});
  endtask
  task automatic drain();
    int n;
    n = 0;
    while ((exp_q.size() != 0 || eng_idle !== 1'b1) && n < 1000) begin
      @(posedge aclk);
      n++;
    end
    check("pending launches", 32'h0, 32'(exp_q.size()));
    exp_q.delete();
  endtask
  function automatic gd_pkg::gd_op_t fb_kind(input int m, input int r);
    if (m == 10) return (r != 0) ? gd_pkg::OP_COPY_UNLOAD : gd_pkg::OP_COPY_LOAD;
    return gd_pkg::gd_op_t'(5'((m < 10) ? m + 1 : m + 2));
  endfunction
  // ====================
  // monitor and timeout
  always @(posedge aclk) begin
    if (aresetn && op_start === 1'b1) begin
      if (exp_q.size() == 0) check("unexpected launch", 32'h0, 32'h1);
      else begin
        e = exp_q.pop_front();
        check("op_kind", 32'(e.k), 32'(op_kind));
        check("op_addr", 32'(e.a), 32'(op_addr));
        if (e.c[0]) check("op_len", 32'(e.l), 32'(op_len));
        if (e.c[1]) check("op_data", e.d, op_data);
        check("op_slope", 32'(e.p[2:0]), 32'(op_slope));
        check("op_deep", 32'(e.p[3]), 32'(op_deep));
      end
    end
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  // ====================
  // scenarios
  initial begin
    void'($urandom(48576));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg({8'h00, gd_pkg::OFS_MODE}, rd);
    check("mode reset", 32'(gd_pkg::MODE_RST), rd);
    for (int m = 0; m < 13; m++) begin
      mode(5'(m), 1'b0);
      for (int r = 0; r < 2; r++) begin
        ofs = 15'($urandom);
        d = $urandom;
        note(fb_kind(m, r), {9'h000, ofs}, fb_len[m], d, 2'h3);
        wr({1'b1, ofs}, d);
      end
    end
    drain();
    opa = 24'($urandom);
    wr({8'h00, gd_pkg::OFS_OPADDR}, {8'h00, opa}); // parameters first
    rd_reg({8'h00, gd_pkg::OFS_OPADDR}, rd);
    check("opaddr", {8'h00, opa}, rd);
    mode(gd_pkg::M_COPY, 1'b1);
    note(gd_pkg::OP_COPY_LOAD, 24'h0, gd_pkg::LEN_COPY_FULL, 32'h0, 2'h1, 4'h8);
    wr(16'h8000, $urandom);
    note(gd_pkg::OP_COPY_UNLOAD, opa, gd_pkg::LEN_COPY_FULL, 32'h0, 2'h1, 4'h8);
    wr({8'h00, gd_pkg::OFS_CDST}, $urandom);
    note(gd_pkg::OP_COPY_LOAD, opa, gd_pkg::LEN_COPY_FULL, 32'h0, 2'h1, 4'h8);
    wr({8'h00, gd_pkg::OFS_CSRC}, $urandom);
    note(gd_pkg::OP_COPY_UNLOAD, 24'h0, gd_pkg::LEN_COPY_FULL, 32'h0, 2'h1, 4'h8);
    wr(16'h8000, $urandom);
    mode(gd_pkg::M_SIMPLE, 1'b0);
    wr({8'h00, gd_pkg::OFS_CSRC}, $urandom); // no launch
    wr(16'h000C, $urandom); // no launch
    rd_reg(16'h000C, rd);
    check("unmapped read", 32'h0, rd);
    note(gd_pkg::OP_PIX, opa, gd_pkg::LEN_WORD, 32'h80000000, 2'h3);
    wr({8'h00, gd_pkg::OFS_CONT}, 32'h80000000);
    d = {8'h00, 24'($urandom)};
    note(gd_pkg::OP_PIX, d[23:0], gd_pkg::LEN_WORD, d, 2'h3);
    wr({8'h00, gd_pkg::OFS_CONT}, d);
    drain();
    mode(gd_pkg::M_LINE_TR, 1'b0);
    for (int s = 0; s < 8; s++) begin
      d = $urandom;
      note(gd_pkg::OP_LINE_1C, opa, gd_pkg::LEN_LINE, d, 2'h3, {1'b0, 3'(s)});
      wr({8'h00, gd_pkg::OFS_SLOPE + 8'(4 * s)}, d);
      note(gd_pkg::OP_LINE_SETUP, opa, 16'h0000, d, 2'h2, {1'b0, 3'(s)});
      wr({8'h00, gd_pkg::OFS_SETUP + 8'(4 * s)}, d);
    end
    d = $urandom;
    note(gd_pkg::OP_LINE_1C, opa, gd_pkg::LEN_LINE, d & gd_pkg::SLOPE_MASK, 2'h3);
    wr({8'h00, gd_pkg::OFS_SPAN}, d);
    note(gd_pkg::OP_LINE_CONT, opa, gd_pkg::LEN_LINE, 32'h80000000, 2'h3);
    wr({8'h00, gd_pkg::OFS_CONT}, 32'h80000000);
    drain();
    for (int m = 13; m < 20; m++) begin
      mode(5'(m), 1'b0);
      wr(16'h8040, $urandom); // no launch
      note(gd_pkg::gd_op_t'(5'(m + 2)), opa, gd_pkg::LEN_LINE, 32'h0, 2'h1);
      wr({8'h00, gd_pkg::OFS_SLOPE}, $urandom);
    end
    mode(gd_pkg::M_L3_SEQ, 1'b1);
    wr({8'h00, gd_pkg::OFS_SLOPE}, $urandom); // no launch at 32 bpp
    drain();
    slow <= 1'b1;
    mode(gd_pkg::M_SIMPLE_Z, 1'b0);
    for (int i = 0; i < 24; i++) begin
      ofs = 15'($urandom);
      note(gd_pkg::OP_PIX_Z, {9'h000, ofs}, gd_pkg::LEN_WORD, 32'h0, 2'h1);
      wr({1'b1, ofs}, $urandom);
      if (i == 12) wr({8'h00, gd_pkg::OFS_STAT}, 32'h0); // barrier
    end
    rd_reg({8'h00, gd_pkg::OFS_STAT}, rd);
    check("busy flag", 32'h1, {31'h0, rd[0]});
    drain();
    rd_reg({8'h00, gd_pkg::OFS_STAT}, rd);
    check("idle status", 32'h0, rd);
    rd_reg({8'h00, gd_pkg::OFS_COUNT}, rd);
    check("launch count", 32'(starts), rd);
    print_verdict();
  end
endmodule // gd_dispatch_test
